/* File: etrx_hash_index.sv */
// Six-bit hash index from the CRC of a destination address
`default_nettype none
`include "etrx_params.svh"

module etrx_hash_index (
   // Address, first wire bit in bit 0
   input  wire logic [`ETRX_DA_W-1:0]  destination_address,
   // Index into the hash table
   output logic [`ETRX_IDX_W-1:0]      index
);

   logic [`ETRX_DA_W:0][31:0] chain;

   assign chain[0] = `ETRX_CRC_INIT;

   // One serial CRC step per address bit, unrolled so the index is ready in a cycle
   genvar i;
   generate
      for (i = 0; i < `ETRX_DA_W; i++) begin : g_step
         logic fb;
         assign fb = chain[i][31] ^ destination_address[i];
         assign chain[i+1] = {chain[i][30:0], 1'b0} ^ (fb ? `ETRX_CRC_POLY : 32'h00000000);
      end
   endgenerate

   // Top six result bits form the index
   assign index = chain[`ETRX_DA_W][31:32-`ETRX_IDX_W]; // R8

endmodule // etrx_hash_index

`default_nettype wire

/* File: etrx_host.sv */
// Host processor model that drives the register port of the block
`default_nettype none
`include "etrx_params.svh"

module etrx_host
   import etrx_pkg::*;
(
   // Clock
   input  wire logic                clk,
   // Register port
   output etrx_bus_t                bus,
   input  wire logic [`ETRX_DW-1:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle port, no strobe, from time zero
   initial bus = '0;

   // Strobe for one cycle, then scramble the released lines so stale values never help
   task automatic wr(input logic [`ETRX_AW-1:0] a, input logic [`ETRX_DW-1:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      @(posedge clk);
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [`ETRX_AW-1:0] a, output logic [`ETRX_DW-1:0] d);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '{addr: ~a, wdata: 16'hffff, wr: 1'b0, rd: 1'b0};
      @(posedge clk);
      d = rdata;
   endtask
endmodule // etrx_host
`default_nettype wire

/* File: etrx_params.svh */
// Constants for the early send/receive and group hash filter block
`ifndef ETRX_PARAMS_SVH
`define ETRX_PARAMS_SVH

// Bus and datapath widths
`define ETRX_AW           8
`define ETRX_DW           16
`define ETRX_CW           11
`define ETRX_TH_W         5
`define ETRX_DA_W         48
`define ETRX_IDX_W        6
`define ETRX_HASH_N       4

// Register offsets
`define ETRX_A_HASH0      8'h00
`define ETRX_A_HASH1      8'h02
`define ETRX_A_HASH2      8'h04
`define ETRX_A_HASH3      8'h06
`define ETRX_A_ESEND      8'h08
`define ETRX_A_ERECV      8'h0a
`define ETRX_A_RXCTL      8'h0c
`define ETRX_A_ISTAT      8'h0e
`define ETRX_A_IMASK      8'h10

// Field positions
`define ETRX_EN_BIT       7
`define ETRX_UNIT_SHIFT   6
`define ETRX_RXC_ALL_BIT  0
`define ETRX_RXC_GRP_BIT  1
`define ETRX_IRQ_ERX_BIT  10
`define ETRX_IRQ_SEND_BIT 0
`define ETRX_ISTAT_IMPL   16'h0401

// Reset values
`define ETRX_SEND_TH_RST  5'h00
`define ETRX_RECV_TH_RST  5'h1f
`define ETRX_WORD_RST     16'h0000

// Hash CRC
`define ETRX_CRC_POLY     32'h04c11db7
`define ETRX_CRC_INIT     32'hffffffff

`endif

/* File: etrx_pkg.sv */
// Types shared by the early send/receive and group hash filter block
`default_nettype none
`include "etrx_params.svh"

package etrx_pkg;

   // Register port request
   typedef struct packed {
      logic [`ETRX_AW-1:0] addr;
      logic [`ETRX_DW-1:0] wdata;
      logic                wr;
      logic                rd;
   } etrx_bus_t;

   // Transmit side view of the current frame
   typedef struct packed {
      logic                pending;
      logic                stored;
      logic                done;
      logic [`ETRX_CW-1:0] bytes;
   } etrx_tx_t;

   // Receive side view of the current frame
   typedef struct packed {
      logic                active;
      logic [`ETRX_CW-1:0] bytes;
   } etrx_rx_t;

   // Destination address offered for filtering
   typedef struct packed {
      logic                  valid;
      logic                  group;
      logic [`ETRX_DA_W-1:0] addr;
   } etrx_da_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_WAIT = 2'b01,
      TX_SEND = 2'b10
   } etrx_tx_state_t;

   // Whole state of the top module
   typedef struct packed {
      logic [`ETRX_HASH_N-1:0][`ETRX_DW-1:0] hash_word;
      logic                                  send_en;
      logic [`ETRX_TH_W-1:0]                 send_th;
      logic                                  recv_en;
      logic [`ETRX_TH_W-1:0]                 recv_th;
      logic                                  rx_all;
      logic                                  rx_grp;
      logic [`ETRX_DW-1:0]                   istat;
      logic [`ETRX_DW-1:0]                   imask;
      etrx_tx_state_t                        tx_state;
      logic                                  rx_crossed;
      logic [`ETRX_DW-1:0]                   rdata;
      logic                                  send_start;
      logic                                  filt_valid;
      logic                                  filt_accept;
   } etrx_state_t;

endpackage : etrx_pkg

`default_nettype wire

/* File: etrx_thresh.sv */
// Byte count against a threshold given in 64-byte units
`default_nettype none
`include "etrx_params.svh"

module etrx_thresh (
   // Control
   input  wire logic                  enable,
   input  wire logic [`ETRX_TH_W-1:0] threshold,
   // Frame progress
   input  wire logic [`ETRX_CW-1:0]   bytes,
   // Result
   output logic                       over
);

   // Threshold shifted into bytes; 31 units still fit the count width
   assign over = enable && (bytes > {threshold, {`ETRX_UNIT_SHIFT{1'b0}}});

endmodule // etrx_thresh

`default_nettype wire

/* File: etrx_top.sv */
// Early send/receive thresholds and group hash filter with register port
//
// Functional notes
// R1: Early send runs while its enable is one, else store-then-send; enable resets zero.
// R2: With early send on, start once stored bytes exceed threshold times 64.
// R3: Host must not leave send threshold zero with early send on; resets zero.
// R4: Early receive runs while its enable is one; enable resets zero.
// R5: Set early receive status once received bytes exceed threshold times 64; resets 0x1f.
// R6: Crossing raises the interrupt only when that source is unmasked.
// R7: Host must not program receive threshold zero with early receive on.
// R8: Hash index is top six bits of CRC over 48-bit destination address.
// R9: Top two index bits pick a hash word, low four pick the bit.
// R10: Accept group frame if selected table bit is one, else drop; table resets zero.
// R11: Accept-every or accept-every-group bit passes all group frames.
// R12: Early receive event latched on its edge in status bit 10; write one clears.
// R13: Word index is top two bits unsigned, bit index the low four directly.
`default_nettype none
`include "etrx_params.svh"

module etrx_top
   import etrx_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                ce,
   // Register port
   input  wire etrx_bus_t           bus,
   output logic [`ETRX_DW-1:0]      rdata,
   // Transmit frame progress
   input  wire etrx_tx_t            tx,
   output logic                     send_start,
   // Receive frame progress
   input  wire etrx_rx_t            rx,
   output logic                     early_receive_status,
   // Group address filter
   input  wire etrx_da_t            da,
   output logic                     filt_valid,
   output logic                     filt_accept,
   // Interrupt
   output logic                     irq
);

   etrx_state_t               st;
   etrx_state_t               next_st;
   logic                      tx_over;
   logic                      rx_over;
   logic                      rx_event;
   logic [`ETRX_IDX_W-1:0]    hash_idx;
   logic                      hash_bit;
   logic                      wr_hit_istat;

   // Threshold compare for the send side
   etrx_thresh u_send_th (
      .enable    (st.send_en),
      .threshold (st.send_th),
      .bytes     (tx.bytes),
      .over      (tx_over)
   );

   // Threshold compare for the receive side
   etrx_thresh u_recv_th (
      .enable    (st.recv_en),
      .threshold (st.recv_th),
      .bytes     (rx.bytes),
      .over      (rx_over)
   );

   // Hash index of the offered address
   etrx_hash_index u_hash (
      .destination_address (da.addr),
      .index               (hash_idx)
   );

   // Word from the top two bits, bit from the low four
   assign hash_bit = st.hash_word[hash_idx[5:4]][hash_idx[3:0]]; // R9 R13

   // First crossing of the current frame only, so the flag sees one edge
   assign rx_event = rx.active && rx_over && !st.rx_crossed; // R5 R12

   assign wr_hit_istat = bus.wr && (bus.addr == `ETRX_A_ISTAT);

   // Next state
   always_comb begin
      next_st = st;
      next_st.send_start = 1'b0;
      next_st.filt_valid = 1'b0;
      next_st.rdata = `ETRX_WORD_RST;

      // Register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `ETRX_A_HASH0: next_st.hash_word[0] = bus.wdata;
            `ETRX_A_HASH1: next_st.hash_word[1] = bus.wdata;
            `ETRX_A_HASH2: next_st.hash_word[2] = bus.wdata;
            `ETRX_A_HASH3: next_st.hash_word[3] = bus.wdata;
            `ETRX_A_ESEND: begin
               next_st.send_en = bus.wdata[`ETRX_EN_BIT]; // R1
               next_st.send_th = bus.wdata[`ETRX_TH_W-1:0];
            end
            `ETRX_A_ERECV: begin
               next_st.recv_en = bus.wdata[`ETRX_EN_BIT]; // R4
               next_st.recv_th = bus.wdata[`ETRX_TH_W-1:0];
            end
            `ETRX_A_RXCTL: begin
               next_st.rx_all = bus.wdata[`ETRX_RXC_ALL_BIT];
               next_st.rx_grp = bus.wdata[`ETRX_RXC_GRP_BIT];
            end
            `ETRX_A_IMASK: next_st.imask = bus.wdata & `ETRX_ISTAT_IMPL;
            default: ;
         endcase
      end

      // Register reads, data valid in the next cycle only
      if (bus.rd) begin
         unique case (bus.addr)
            `ETRX_A_HASH0: next_st.rdata = st.hash_word[0];
            `ETRX_A_HASH1: next_st.rdata = st.hash_word[1];
            `ETRX_A_HASH2: next_st.rdata = st.hash_word[2];
            `ETRX_A_HASH3: next_st.rdata = st.hash_word[3];
            `ETRX_A_ESEND: next_st.rdata = (16'(st.send_en) << `ETRX_EN_BIT) | 16'(st.send_th);
            `ETRX_A_ERECV: next_st.rdata = (16'(st.recv_en) << `ETRX_EN_BIT) | 16'(st.recv_th);
            `ETRX_A_RXCTL: next_st.rdata = (16'(st.rx_all) << `ETRX_RXC_ALL_BIT)
                                         | (16'(st.rx_grp) << `ETRX_RXC_GRP_BIT);
            `ETRX_A_ISTAT: next_st.rdata = st.istat;
            `ETRX_A_IMASK: next_st.rdata = st.imask;
            default:       next_st.rdata = `ETRX_WORD_RST;
         endcase
      end

      // Transmit sequencing
      unique case (st.tx_state)
         TX_IDLE: begin
            if (tx.pending) begin
               next_st.tx_state = TX_WAIT;
            end
         end
         TX_WAIT: begin
            // Early start needs the enable; otherwise wait for the whole frame
            if (tx_over || tx.stored) begin // R1 R2
               next_st.send_start = 1'b1;
               next_st.tx_state = TX_SEND;
            end
         end
         TX_SEND: begin
            if (tx.done) begin
               next_st.tx_state = TX_IDLE;
            end
         end
         default: next_st.tx_state = TX_IDLE;
      endcase

      // Per-frame crossing memory, dropped when the frame ends
      if (!rx.active) begin
         next_st.rx_crossed = 1'b0;
      end else if (rx_event) begin
         next_st.rx_crossed = 1'b1; // R5
      end

      // Sticky status: write one clears, a new event in the same cycle wins
      if (wr_hit_istat) begin
         next_st.istat = st.istat & ~bus.wdata; // R12
      end
      if (rx_event) begin
         next_st.istat[`ETRX_IRQ_ERX_BIT] = 1'b1; // R12
      end
      if (next_st.send_start && st.send_en) begin
         next_st.istat[`ETRX_IRQ_SEND_BIT] = 1'b1;
      end

      // Group filter decision, one cycle after the address is offered
      if (da.valid) begin
         next_st.filt_valid = 1'b1;
         next_st.filt_accept = !da.group || st.rx_all || st.rx_grp || hash_bit; // R10 R11
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st <= '0;
         st.send_th <= `ETRX_SEND_TH_RST;
         st.recv_th <= `ETRX_RECV_TH_RST; // R5
         st.tx_state <= TX_IDLE;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // Outputs
   assign rdata = st.rdata;
   assign send_start = st.send_start;
   assign early_receive_status = st.rx_crossed;
   assign filt_valid = st.filt_valid;
   assign filt_accept = st.filt_accept;
   // Only unmasked sources reach the line
   assign irq = |(st.istat & st.imask); // R6

   // Checks
   // All share the system clock; reset disables them, so $past and $fell
   // are only trusted from the first edge after release
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence tx_wait_early;
      ce && st.tx_state == TX_WAIT && st.send_en && tx_over;
   endsequence

   sequence tx_wait_store;
      ce && st.tx_state == TX_WAIT && !st.send_en && !tx.stored;
   endsequence

   tx_early_go_a: assert property (tx_wait_early |=> send_start && st.tx_state == TX_SEND) // R2
      else $error("early send did not start after threshold");

   tx_store_hold_a: assert property (tx_wait_store |=> !send_start ##0 st.tx_state == TX_WAIT) // R1
      else $error("send started before frame stored");

   rx_status_set_a: assert property (ce && rx_event |=> early_receive_status && st.istat[10]) // R5
      else $error("early receive status not set on crossing");

   rx_flag_kept_a: assert property (st.istat[10] && !(ce && wr_hit_istat && bus.wdata[10])
                                    |=> st.istat[10]) // R12
      else $error("early receive flag lost without a clear");

   rx_flag_clear_a: assert property (ce && wr_hit_istat && bus.wdata[10] && !rx_event
                                     |=> !st.istat[10]) // R12
      else $error("early receive flag not cleared by write one");

   irq_masked_a: assert property (ce && rx_event && !st.imask[10] && (st.istat & st.imask) == 16'h0000
                                  && !(next_st.send_start && st.send_en)
                                  && !(bus.wr && bus.addr == `ETRX_A_IMASK)
                                  |=> !irq) // R6
      else $error("masked early receive raised the interrupt");

   hash_pick_a: assert property (ce && da.valid && da.group && !st.rx_all && !st.rx_grp
                                 |=> filt_valid && filt_accept == $past(hash_bit)) // R9 R10
      else $error("hash filter decision does not match table bit");

   all_group_a: assert property (ce && da.valid && (st.rx_all || st.rx_grp)
                                 |=> filt_valid && filt_accept) // R11
      else $error("accept-all bits did not pass group frame");

   reset_vals_a: assert property ($fell(sys_rst) |-> !st.send_en && !st.recv_en
                                  && st.recv_th == `ETRX_RECV_TH_RST
                                  && st.hash_word == '0) // R4
      else $error("wrong values after reset");

   crossed_once_a: assert property (ce && rx_event ##1 ce && rx.active |-> !rx_event) // R12
      else $error("early receive event repeated within one frame");

   // Read data fall back to zero whenever no read was taken
   sequence rd_none;
      ce && !bus.rd;
   endsequence

   rdata_idle_a: assert property (rd_none |=> rdata == `ETRX_WORD_RST)
      else $error("read data did not return to zero");

   // A hash word write lands in the next cycle
   hash_write_a: assert property (ce && bus.wr && bus.addr == `ETRX_A_HASH0
                                  |=> st.hash_word[0] == $past(bus.wdata)) // R10
      else $error("hash word write did not land");

   // Start strobe is a single-cycle pulse
   send_pulse_a: assert property (ce && send_start |=> !send_start) // R2
      else $error("send start longer than one cycle");

   // Sending phase ends only on done, with no second start inside it
   sequence tx_sending;
      ce && st.tx_state == TX_SEND && !tx.done;
   endsequence

   tx_send_hold_a: assert property (tx_sending |=> st.tx_state == TX_SEND && !send_start)
      else $error("left sending phase before done");

   // An unmasked crossing must reach the line; a mask write in that cycle is left out
   irq_unmasked_a: assert property (ce && rx_event && st.imask[`ETRX_IRQ_ERX_BIT]
                                    && !(bus.wr && bus.addr == `ETRX_A_IMASK)
                                    |=> irq) // R6
      else $error("unmasked early receive did not raise the interrupt");

   // Status lives only as long as its frame
   rx_status_end_a: assert property (ce && !rx.active |=> !early_receive_status) // R5
      else $error("early receive status outlived its frame");

   // With early receive off no crossing is ever recorded
   recv_off_quiet_a: assert property (ce && !st.recv_en && !st.rx_crossed
                                      |=> !early_receive_status) // R4
      else $error("early receive status set while disabled");

   // Individual addresses are never filtered
   unicast_pass_a: assert property (ce && da.valid && !da.group |=> filt_valid && filt_accept) // R10
      else $error("individual address was dropped");

   // Low clock enable freezes every state bit
   ce_freeze_a: assert property (!ce |=> st == $past(st))
      else $error("state moved while clock enable was low");

endmodule // etrx_top

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the early send/receive and group hash filter block
`default_nettype none
`include "etrx_params.svh"

module tb_top
   import etrx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0]  a;
      logic [15:0] d;
      logic [15:0] r;
      logic [15:0] e;
   } etrx_row_t;

   logic                clk;
   logic                sys_rst;
   logic                ce;
   etrx_bus_t           bus;
   logic [`ETRX_DW-1:0] rdata;
   etrx_tx_t            tx;
   etrx_rx_t            rx;
   etrx_da_t            da;
   logic                send_start;
   logic                early_receive_status;
   logic                filt_valid;
   logic                filt_accept;
   logic                irq;
   int                  errors;
   int                  compares;
   logic [15:0]         v;
   logic [15:0]         m;
   logic [5:0]          ix;
   logic [47:0]         a;

   // Address, written value, reset value, value read back
   etrx_row_t rows [8] = '{
      '{8'h00, 16'ha5c3, 16'h0000, 16'ha5c3},
      '{8'h02, 16'h5a3c, 16'h0000, 16'h5a3c},
      '{8'h04, 16'hffff, 16'h0000, 16'hffff},
      '{8'h06, 16'h0001, 16'h0000, 16'h0001},
      '{8'h08, 16'hffe1, 16'h0000, 16'h0081},
      '{8'h0a, 16'h0060, 16'h001f, 16'h0000},
      '{8'h10, 16'hffff, 16'h0000, 16'h0401},
      '{8'h12, 16'hffff, 16'h0000, 16'h0000}
   };

   etrx_top etrx_top_inst (
      .clk                  (clk),
      .sys_rst              (sys_rst),
      .ce                   (ce),
      .bus                  (bus),
      .rdata                (rdata),
      .tx                   (tx),
      .send_start           (send_start),
      .rx                   (rx),
      .early_receive_status (early_receive_status),
      .da                   (da),
      .filt_valid           (filt_valid),
      .filt_accept          (filt_accept),
      .irq                  (irq)
   );

   etrx_host etrx_host_inst (
      .clk   (clk),
      .bus   (bus),
      .rdata (rdata)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic note(input string s);
      $display("test done: %s", s);
   endtask

   task automatic end_sim();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      etrx_host_inst.wr(ad, d);
   endtask

   task automatic rc(input logic [7:0] ad, input logic [15:0] e);
      etrx_host_inst.rd(ad, v);
      chk(v, e);
   endtask

   // Reference index: serial CRC, first wire bit first, top six bits kept
   function automatic logic [5:0] hidx(input logic [47:0] d);
      logic [31:0] c;
      c = `ETRX_CRC_INIT;
      for (int i = 0; i < 48; i++)
         c = (c << 1) ^ ((c[31] ^ d[i]) ? `ETRX_CRC_POLY : 32'h0);
      return c[31:26];
   endfunction

   // Offer one address; decision is taken in the cycle after the pulse
   task automatic filt(input logic [47:0] d, input logic g, input logic e);
      da <= '{valid: 1'b1, group: g, addr: d};
      @(posedge clk);
      da <= '{valid: 1'b0, group: g, addr: ~d};
      @(posedge clk);
      chk(filt_valid, 1'b1);
      chk(filt_accept, e);
   endtask

   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      end_sim();
   end

   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      tx = '0;
      rx = '0;
      da = '0;
      errors = 0;
      compares = 0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      // Reset value, write, read back for every row
      foreach (rows[i]) begin
         rc(rows[i].a, rows[i].r);
         wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e);
      end
      note("register table");
      // Early receive off: no status past the threshold
      wr(`ETRX_A_ERECV, 16'h0001);
      rx <= '{active: 1'b1, bytes: 11'd65};
      repeat (3) @(posedge clk);
      chk(early_receive_status, 1'b0);
      rx <= '0;
      @(posedge clk);
      // Crossing one unit, first unmasked, then masked
      for (int k = 0; k < 2; k++) begin
         wr(`ETRX_A_IMASK, k ? 16'h0000 : 16'h0400);
         wr(`ETRX_A_ERECV, 16'h0081);
         rx <= '{active: 1'b1, bytes: 11'd64};
         repeat (3) @(posedge clk);
         chk(early_receive_status, 1'b0);
         rx.bytes <= 11'd65;
         repeat (2) @(posedge clk);
         chk(early_receive_status, 1'b1);
         chk(irq, !k);
         rc(`ETRX_A_ISTAT, 16'h0400);
         wr(`ETRX_A_ISTAT, 16'h0400);
         rc(`ETRX_A_ISTAT, 16'h0000);
         chk(irq, 1'b0);
         rx.active <= 1'b0;
         repeat (2) @(posedge clk);
         chk(early_receive_status, 1'b0);
      end
      note("early receive");
      // Store-then-send while off, then early start just past two units
      for (int k = 0; k < 2; k++) begin
         wr(`ETRX_A_ESEND, k ? 16'h0082 : 16'h0002);
         tx <= '{pending: 1'b1, stored: 1'b0, done: 1'b0, bytes: k ? 11'd128 : 11'd1900};
         repeat (3) @(posedge clk);
         chk(send_start, 1'b0);
         if (k)
            tx.bytes <= 11'd129;
         else
            tx.stored <= 1'b1;
         repeat (2) @(posedge clk);
         chk(send_start, 1'b1);
         @(posedge clk);
         chk(send_start, 1'b0);
         tx <= '{pending: 1'b0, stored: 1'b0, done: 1'b1, bytes: 11'd0};
         @(posedge clk);
         tx.done <= 1'b0;
         @(posedge clk);
      end
      note("early send");
      // Set only the selected bit, then every bit but it
      for (int k = 0; k < 6; k++) begin
         a = 48'h0000_5e00_0001 + 48'(k) * 48'h0107_0300;
         ix = hidx(a);
         m = 16'h0001 << ix[3:0];
         wr({5'h0, ix[5:4], 1'b0}, m);
         filt(a, 1'b1, 1'b1);
         wr({5'h0, ix[5:4], 1'b0}, ~m);
         filt(a, 1'b1, 1'b0);
      end
      wr(`ETRX_A_RXCTL, 16'h0001);
      filt(a, 1'b1, 1'b1);
      wr(`ETRX_A_RXCTL, 16'h0002);
      rc(`ETRX_A_RXCTL, 16'h0002);
      filt(a, 1'b1, 1'b1);
      wr(`ETRX_A_RXCTL, 16'h0000);
      filt(a, 1'b1, 1'b0);
      filt(a, 1'b0, 1'b1);
      note("hash filter");
      // Frozen clock enable drops a write; mid-run reset restores defaults
      ce <= 1'b0;
      wr(`ETRX_A_ESEND, 16'h0085);
      ce <= 1'b1;
      rc(`ETRX_A_ESEND, 16'h0082);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rc(`ETRX_A_ESEND, 16'h0000);
      rc(`ETRX_A_ERECV, 16'h001f);
      rc({5'h0, ix[5:4], 1'b0}, 16'h0000);
      chk(irq, 1'b0);
      note("reset");
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
